/* logic/acl_defines.svh */
// Offsets, field positions, codes and timing counts of the access-control action block
// Function
// - Priority mode 0: keep QoS priority
// - Priority mode 1: take new value if greater
// - Priority mode 2: take new value if smaller
// - Priority mode 3: always take new value
// - Remark enable replaces PCP with remark value
// - Map mode 0: lookup map unchanged
// - Map mode 1: OR rule map into lookup
// - Map mode 2: AND rule map with lookup
// - Map mode 3: rule map replaces lookup
// - Map bit k forwards to port k+1
// - Time unit: 0 microsecond, 1 millisecond
// - Algorithm 1: count packets, interrupt at terminal
// - Packet counter resets at terminal, ignores unit
// - Table holds sixteen entries
// - Fields independent except in count mode
// - Only count-mode events raise interrupts
// - Per-port interrupt status and mask bits
// - Global per-port status gated by port mask; global mask gates the output
// - Count mode: layer 01 with compare 00
// - Count value taken from action bits
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH

// Register byte offsets
`define ACL_OFS_PORT_STAT  8'h00
`define ACL_OFS_PORT_MASK  8'h04
`define ACL_OFS_GLOB_STAT  8'h08
`define ACL_OFS_GLOB_MASK  8'h0c
`define ACL_ENTRY_PAGE     2'h1
`define ACL_ENTRIES        16

// Entry word layout
`define ACL_F_LAYER_LO     0
`define ACL_F_CMP_LO       2
`define ACL_F_PMODE_LO     4
`define ACL_F_PRIO_LO      6
`define ACL_F_RMK_EN       9
`define ACL_F_RMK_LO       10
`define ACL_F_MAP_LO       13
`define ACL_F_COUNT_LO     4
`define ACL_F_TU           15
`define ACL_F_CA           16
`define ACL_F_FWD_LO       17

// Mode codes
`define ACL_LAYER_L2       2'h1
`define ACL_CMP_COUNT      2'h0
`define ACL_MODE_KEEP      2'h0
`define ACL_MODE_RAISE     2'h1
`define ACL_MODE_LOWER     2'h2
`define ACL_MODE_FORCE     2'h3

// Timing
`define ACL_CLK_PERIOD_NS  8
`define ACL_US_NS          1000
`define ACL_CYC_PER_US     (`ACL_US_NS / `ACL_CLK_PERIOD_NS)
`define ACL_MS_US          1000
`define ACL_US_PER_MS      (`ACL_MS_US)

`endif

/* logic/acl_pkg.sv */
// Types shared by the access-control action block
package acl_pkg;
    typedef logic [31:0] acl_word_t;
    typedef logic [10:0] acl_count_t;
    typedef logic [2:0]  acl_prio_t;
    typedef enum logic [0:0] {CNT_IDLE, CNT_TIMING} acl_cnt_state_t;
endpackage : acl_pkg

/* logic/acl_action_unit.sv */
// Priority, remark and forwarding-map action of one matched entry
`include "acl_defines.svh"
module acl_action_unit
    import acl_pkg::*;
#(
    parameter int NPORTS = 7
) (
    input  wire logic              clk_sys,
    input  wire logic              rstSync_n,
    input  wire acl_word_t         entryWord,
    input  wire logic              hit,
    input  wire acl_prio_t         qosPrio,
    input  wire acl_prio_t         pcpIn,
    input  wire logic [NPORTS-1:0] lookupMap,
    output acl_prio_t              nextPrio,
    output acl_prio_t              nextPcp,
    output logic [NPORTS-1:0]      nextMap
);
    logic              isCount;
    logic [1:0]        pMode;
    logic [1:0]        mMode;
    acl_prio_t         newPrio;
    logic [NPORTS-1:0] ruleMap;

    // Field extraction; count entries carry a count value here instead
    assign isCount = entryWord[`ACL_F_LAYER_LO +: 2] == `ACL_LAYER_L2
                  && entryWord[`ACL_F_CMP_LO +: 2] == `ACL_CMP_COUNT;
    assign pMode   = entryWord[`ACL_F_PMODE_LO +: 2];
    assign mMode   = entryWord[`ACL_F_MAP_LO +: 2];
    assign newPrio = entryWord[`ACL_F_PRIO_LO +: 3];
    assign ruleMap = entryWord[`ACL_F_FWD_LO +: NPORTS];

    // Priority selection
    always_comb begin
        nextPrio = qosPrio;
        if (hit && !isCount) begin
            case (pMode)
                `ACL_MODE_KEEP:  nextPrio = qosPrio;
                `ACL_MODE_RAISE: nextPrio = (newPrio > qosPrio) ? newPrio : qosPrio;
                `ACL_MODE_LOWER: nextPrio = (newPrio < qosPrio) ? newPrio : qosPrio;
                default:         nextPrio = newPrio;
            endcase
        end
    end

    // PCP remarking
    assign nextPcp = (hit && !isCount && entryWord[`ACL_F_RMK_EN]) ?
                     entryWord[`ACL_F_RMK_LO +: 3] : pcpIn;

    // Forwarding map
    always_comb begin
        nextMap = lookupMap;
        if (hit && !isCount) begin
            case (mMode)
                2'h0:    nextMap = lookupMap;
                2'h1:    nextMap = lookupMap | ruleMap;
                2'h2:    nextMap = lookupMap & ruleMap;
                default: nextMap = ruleMap;
            endcase
        end
    end

    a_prio_force: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        hit && !isCount && pMode == `ACL_MODE_FORCE |-> nextPrio == newPrio)
        else $error("forced priority not applied");
    a_prio_raise: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        hit && !isCount && pMode == `ACL_MODE_RAISE |-> nextPrio >= qosPrio && nextPrio >= newPrio)
        else $error("raise mode lost the larger priority");
    a_map_replace: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        hit && !isCount && mMode == 2'h3 |-> nextMap == ruleMap)
        else $error("rule map did not replace lookup map");
    a_count_pass: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        isCount |-> nextMap == lookupMap && nextPrio == qosPrio && nextPcp == pcpIn)
        else $error("count entry altered the packet");
endmodule : acl_action_unit

/* logic/acl_count_unit.sv */
// Count-mode engine of one entry: inactivity timer or packet counter
`include "acl_defines.svh"
module acl_count_unit
    import acl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstSync_n,
    input  wire logic       enable,
    input  wire logic       algo,
    input  wire logic       unitMs,
    input  wire acl_count_t countVal,
    input  wire logic       tickUs,
    input  wire logic       tickMs,
    input  wire logic       match,
    output logic            expired
);
    acl_cnt_state_t state;
    acl_count_t     count;
    logic           tick;

    // Packet counting never looks at the tick
    assign tick = unitMs ? tickMs : tickUs;

    // Timer and counter share one 11-bit register
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state   <= CNT_IDLE;
            count   <= 11'h000;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (!enable) begin
                state <= CNT_IDLE;
                count <= 11'h000;
            end else if (algo) begin
                state <= CNT_IDLE;
                if (match) begin
                    if (count + 11'h001 >= countVal) begin
                        count   <= 11'h000;
                        expired <= 1'b1;
                    end else begin
                        count <= count + 11'h001;
                    end
                end
            end else begin
                case (state)
                    CNT_IDLE: begin
                        if (match) begin
                            count <= countVal;
                            state <= CNT_TIMING;
                        end
                    end
                    CNT_TIMING: begin
                        if (match) begin
                            count <= countVal;
                        end else if (tick) begin
                            if (count <= 11'h001) begin
                                count   <= 11'h000;
                                expired <= 1'b1;
                                state   <= CNT_IDLE;
                            end else begin
                                count <= count - 11'h001;
                            end
                        end
                    end
                    default: state <= CNT_IDLE;
                endcase
            end
        end
    end

    sequence s_last_packet;
        enable && algo && match && count + 11'h001 >= countVal;
    endsequence
    a_pkt_terminal: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        s_last_packet |=> expired && count == 11'h000)
        else $error("terminal count did not fire or reset");
    a_timer_quiet: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        enable && !algo && match |=> !expired && count == $past(countVal))
        else $error("timer not reloaded by packet");
endmodule : acl_count_unit

/* logic/acl_action_and_count.sv */
// Top of the access-control action and count block with its Avalon-MM register slave
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`include "acl_defines.svh"
module acl_action_and_count
    import acl_pkg::*;
#(
    parameter int NPORTS     = 7,
    parameter int CYC_PER_US = `ACL_CYC_PER_US,
    parameter int US_PER_MS  = `ACL_US_PER_MS,
    parameter int PW         = $clog2(NPORTS)
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              lkpValid,
    input  wire logic              lkpHit,
    input  wire logic [3:0]        lkpEntry,
    input  wire logic [PW-1:0]     lkpPort,
    input  wire acl_prio_t         qosPrio,
    input  wire acl_prio_t         pcpIn,
    input  wire logic [NPORTS-1:0] lookupMap,
    output logic                   actValid,
    output acl_prio_t              actPrio,
    output acl_prio_t              actPcp,
    output logic [NPORTS-1:0]      actMap,
    output logic                   irqOut
);
    localparam int NE = `ACL_ENTRIES;

    logic              rstMeta_n;
    logic              rstSync_n;
    logic              ack;
    logic              wrFire;
    logic              entryHit;
    logic [3:0]        entrySel;
    acl_word_t         entryTab [NE];
    logic [NPORTS-1:0] portStat;
    logic [NPORTS-1:0] portMask;
    logic [NPORTS-1:0] globStat;
    logic [NPORTS-1:0] globMask;
    logic [NPORTS-1:0] setVec;
    logic [NPORTS-1:0] clrVec;
    logic [NE-1:0]     isCount;
    logic [NE-1:0]     entryMatch;
    logic [NE-1:0]     entryExpired;
    logic [PW-1:0]     entryPort [NE];
    logic [7:0]        usCount;
    logic [9:0]        msCount;
    logic              tickUs;
    logic              tickMs;
    acl_prio_t         next_prio;
    acl_prio_t         next_pcp;
    logic [NPORTS-1:0] next_map;
    logic [31:0]       next_readdata;

    // Reset release through two flops; assertion is immediate
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // Bus decode: entries sit in the second 64-byte page
    assign entryHit = avs_address[7:6] == `ACL_ENTRY_PAGE;
    assign entrySel = avs_address[5:2];
    assign wrFire   = avs_write && ack;
    assign avs_waitrequest = (avs_read || avs_write) && !ack;   // Fixed one wait state

    // Byte-enable merge for partial writes
    function automatic logic [31:0] acl_merge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = oldVal;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = newVal[8*b +: 8];
            end
        end
        return res;
    endfunction : acl_merge

    // Handshake: ack rises one cycle into each request and drops after it
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (entryHit) begin
            next_readdata = entryTab[entrySel];
        end else begin
            case (avs_address)
                `ACL_OFS_PORT_STAT: next_readdata[NPORTS-1:0] = portStat;
                `ACL_OFS_PORT_MASK: next_readdata[NPORTS-1:0] = portMask;
                `ACL_OFS_GLOB_STAT: next_readdata[NPORTS-1:0] = globStat;
                `ACL_OFS_GLOB_MASK: next_readdata[NPORTS-1:0] = globMask;
                default:            next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured while waitrequest is still high, so it stands at the answer edge
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_readdata;
        end
    end

    // Sixteen-entry action table, written only at the answer edge
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            for (int i = 0; i < NE; i++) begin
                entryTab[i] <= 32'h0000_0000;
            end
        end else if (wrFire && entryHit) begin
            entryTab[entrySel] <= acl_merge(entryTab[entrySel], avs_writedata, avs_byteenable);
        end
    end

    // Mask registers
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            portMask <= '0;
            globMask <= '0;
        end else if (wrFire && !entryHit && avs_byteenable[0]) begin
            if (avs_address == `ACL_OFS_PORT_MASK) begin
                portMask <= avs_writedata[NPORTS-1:0];
            end
            if (avs_address == `ACL_OFS_GLOB_MASK) begin
                globMask <= avs_writedata[NPORTS-1:0];
            end
        end
    end

    // Microsecond prescaler; milliseconds counted in microsecond ticks
    assign tickUs = usCount == 8'(CYC_PER_US - 1);
    assign tickMs = tickUs && msCount == 10'(US_PER_MS - 1);
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            usCount <= 8'h00;
            msCount <= 10'h000;
        end else begin
            usCount <= tickUs ? 8'h00 : usCount + 8'h01;
            if (tickUs) begin
                msCount <= tickMs ? 10'h000 : msCount + 10'h001;
            end
        end
    end

    // Count engines, one per entry, each remembering its last ingress port
    for (genvar e = 0; e < NE; e++) begin : g_entry
        assign isCount[e] = entryTab[e][`ACL_F_LAYER_LO +: 2] == `ACL_LAYER_L2
                         && entryTab[e][`ACL_F_CMP_LO +: 2] == `ACL_CMP_COUNT;
        assign entryMatch[e] = lkpValid && lkpHit && lkpEntry == 4'(e) && isCount[e];

        always_ff @(posedge clk_sys or negedge rstSync_n) begin
            if (!rstSync_n) begin
                entryPort[e] <= '0;
            end else if (entryMatch[e]) begin
                entryPort[e] <= lkpPort;
            end
        end

        acl_count_unit u_count (
            .clk_sys   (clk_sys),
            .rstSync_n (rstSync_n),
            .enable    (isCount[e]),
            .algo      (entryTab[e][`ACL_F_CA]),
            .unitMs    (entryTab[e][`ACL_F_TU]),
            .countVal  (entryTab[e][`ACL_F_COUNT_LO +: 11]),
            .tickUs    (tickUs),
            .tickMs    (tickMs),
            .match     (entryMatch[e]),
            .expired   (entryExpired[e])
        );
    end

    // Only count-engine expiries reach the status bits
    always_comb begin
        setVec = '0;
        for (int e = 0; e < NE; e++) begin
            if (entryExpired[e]) begin
                setVec[entryPort[e]] = 1'b1;
            end
        end
    end
    assign clrVec = (wrFire && !entryHit && avs_address == `ACL_OFS_PORT_STAT && avs_byteenable[0]) ?
                    avs_writedata[NPORTS-1:0] : '0;

    // Sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            portStat <= '0;
        end else begin
            portStat <= (portStat & ~clrVec) | setVec;
        end
    end

    // Global view per port, then the single output
    assign globStat = portStat & portMask;
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= |(globStat & globMask);
        end
    end

    acl_action_unit #(
        .NPORTS (NPORTS)
    ) u_action (
        .clk_sys   (clk_sys),
        .rstSync_n (rstSync_n),
        .entryWord (entryTab[lkpEntry]),
        .hit       (lkpHit),
        .qosPrio   (qosPrio),
        .pcpIn     (pcpIn),
        .lookupMap (lookupMap),
        .nextPrio  (next_prio),
        .nextPcp   (next_pcp),
        .nextMap   (next_map)
    );

    // Result registered one cycle after the lookup request
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            actValid <= 1'b0;
            actPrio  <= 3'h0;
            actPcp   <= 3'h0;
            actMap   <= '0;
        end else begin
            actValid <= lkpValid;
            if (lkpValid) begin
                actPrio <= next_prio;
                actPcp  <= next_pcp;
                actMap  <= next_map;
            end
        end
    end

    sequence s_bus_req;
        (avs_read || avs_write) && !ack;
    endsequence
    sequence s_bus_done;
        ack && !avs_waitrequest;
    endsequence
    a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        s_bus_req |=> s_bus_done)
        else $error("bus answer not after one wait state");
    a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (globStat & globMask) == '0 |=> !irqOut)
        else $error("interrupt without both masks open");
    a_stat_sticky: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        portStat != '0 && clrVec == '0 |=> (portStat & $past(portStat)) == $past(portStat))
        else $error("status bit dropped without a clear");
    a_set_wins: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        setVec != '0 |=> (portStat & $past(setVec)) == $past(setVec))
        else $error("event lost against clear");
    a_no_filter_irq: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        entryExpired == '0 |=> (portStat & ~$past(portStat)) == '0)
        else $error("status set without count event");
    a_us_period: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        tickUs |=> !tickUs [*2])
        else $error("microsecond ticks too close");
    a_result_latency: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        lkpValid && (!lkpHit || isCount[lkpEntry]) |=> actValid && actMap == $past(lookupMap))
        else $error("unmatched packet map altered");
endmodule : acl_action_and_count

/* verif/acl_pipe_model.sv */
// Behavioural lookup and classification pipeline feeding the action block
module acl_pipe_model
    import acl_pkg::*;
#(
    parameter int NPORTS = 7,
    parameter int PW     = 3
) (
    input  wire logic         clk_sys,
    output logic              lkpValid,
    output logic              lkpHit,
    output logic [3:0]        lkpEntry,
    output logic [PW-1:0]     lkpPort,
    output acl_prio_t         qosPrio,
    output acl_prio_t         pcpIn,
    output logic [NPORTS-1:0] lookupMap
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet pipeline until the first lookup
    initial begin
        {lkpValid, lkpHit, lkpEntry, lkpPort, qosPrio, pcpIn, lookupMap} = '0;
    end

    // One lookup per call; fields are scrambled once released so stale values cannot pass
    task automatic packet(input logic h, input logic [3:0] e, input logic [PW-1:0] p,
                          input acl_prio_t q, input acl_prio_t c, input logic [NPORTS-1:0] m);
        @(posedge clk_sys);
        lkpValid <= 1'b1;
        {lkpHit, lkpEntry, lkpPort, qosPrio, pcpIn, lookupMap} <= {h, e, p, q, c, m};
        @(posedge clk_sys);
        lkpValid <= 1'b0;
        {lkpHit, lkpEntry, lkpPort, qosPrio, pcpIn, lookupMap} <= ~{h, e, p, q, c, m};
    endtask : packet
endmodule : acl_pipe_model

/* verif/tb_acl_action_and_count_logic.sv */
// Self-checking bench of the access-control action and count block
module tb_acl_action_and_count_logic;
    import acl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 7;
    logic clk_sys, reset_n, avsRead, avsWrite, avsWait, lkpValid, lkpHit, actValid, irqOut;
    logic [7:0] avsAddr;
    logic [31:0] avsWdata, avsRdata, rd, w, seed;
    logic [3:0] avsBe, lkpEntry;
    logic [2:0] lkpPort;
    acl_prio_t qosPrio, pcpIn, actPrio, actPcp, q, c;
    logic [NP-1:0] lookupMap, actMap, m;
    logic [12:0] ex;
    int num_errors, check_count;

    // Small tick counts keep the timer scenarios short
    acl_action_and_count #(.NPORTS(NP), .CYC_PER_US(4), .US_PER_MS(2)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avsAddr), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(avsBe),
        .avs_readdata(avsRdata), .avs_waitrequest(avsWait), .lkpValid(lkpValid), .lkpHit(lkpHit),
        .lkpEntry(lkpEntry), .lkpPort(lkpPort), .qosPrio(qosPrio), .pcpIn(pcpIn),
        .lookupMap(lookupMap), .actValid(actValid), .actPrio(actPrio), .actPcp(actPcp),
        .actMap(actMap), .irqOut(irqOut));
    acl_pipe_model #(.NPORTS(NP), .PW(3)) pipe (
        .clk_sys(clk_sys), .lkpValid(lkpValid), .lkpHit(lkpHit), .lkpEntry(lkpEntry),
        .lkpPort(lkpPort), .qosPrio(qosPrio), .pcpIn(pcpIn), .lookupMap(lookupMap));

    // Xorshift source with a fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Priority, remark and map result expected for a hit on a filtering entry
    function automatic logic [12:0] expAct(acl_word_t x, acl_prio_t qp, acl_prio_t cp, logic [NP-1:0] lm);
        acl_prio_t p = qp;
        logic [NP-1:0] o = lm;
        case (x[5:4])
            2'h1: if (x[8:6] > qp) p = x[8:6];
            2'h2: if (x[8:6] < qp) p = x[8:6];
            2'h3: p = x[8:6];
            default: p = qp;
        endcase
        case (x[14:13])
            2'h1: o = lm | x[23:17];
            2'h2: o = lm & x[23:17];
            2'h3: o = x[23:17];
            default: o = lm;
        endcase
        return {p, x[9] ? x[12:10] : cp, o};
    endfunction : expAct

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Avalon-MM master: request held until waitrequest is sampled low
    task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avsAddr <= a;
        avsWdata <= d;
        avsWrite <= 1'b1;
        do @(posedge clk_sys); while (avsWait);
        avsWrite <= 1'b0;
    endtask : busWrite

    task automatic busRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        avsAddr <= a;
        avsRead <= 1'b1;
        do @(posedge clk_sys); while (avsWait);
        d = avsRdata;
        avsRead <= 1'b0;
    endtask : busRead

    task automatic test_done();
        if (num_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    // Clock, 8 ns period
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        test_done();
    end

    initial begin
        {reset_n, avsRead, avsWrite, avsAddr, avsWdata} = '0;
        avsBe = 4'hf;
        seed = 32'h6;
        num_errors = 0;
        check_count = 0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Random filtering entries, every priority and map mode, hits and misses
        for (int i = 0; i < 64; i++) begin
            w = rnd();
            w[1:0] = i[4] ? 2'h1 : 2'h2;
            w[3:2] = 2'h3;
            w[5:4] = i[1:0];
            w[14:13] = i[3:2];
            {q, c, m} = 13'(rnd());
            busWrite(8'h40 + 8'(4 * i[3:0]), w);
            pipe.packet(i % 3 != 0, i[3:0], 3'(i % NP), q, c, m);
            @(negedge clk_sys);
            chk("actValid", 1, actValid);
            ex = i % 3 != 0 ? expAct(w, q, c, m) : {q, c, m};
            chk("prioPcp", ex[12:7], {actPrio, actPcp});
            chk("map", ex[6:0], actMap);
        end
        busRead(8'h30, rd);
        chk("unmapped", 0, rd);
        // Packet counter, terminal three, on ingress port index 2
        busWrite(8'h04, 32'h7f);
        busWrite(8'h0c, 32'h7f);
        busWrite(8'h54, 32'h0001_0031);
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 3; k++) begin
                repeat (3) @(negedge clk_sys);
                chk("irqEarly", 0, irqOut); // Before terminal
                pipe.packet(1'b1, 4'h5, 3'h2, 3'h5, 3'h6, 7'h15);
                @(negedge clk_sys);
                chk("countPass", {3'h5, 3'h6, 7'h15}, {actPrio, actPcp, actMap});
            end
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("irqTerm", r == 0, irqOut); // Global mask gates output
            busRead(8'h08, rd);
            chk("globStat", 32'h04, rd); // Per-port status
            busWrite(8'h0c, 32'h00);
        end
        // Status stays set with no clear written; global mask reopened
        busRead(8'h00, rd);
        chk("portStat", 32'h04, rd); // Sticky
        busWrite(8'h0c, 32'h7f);
        // Inactivity timer, two units of 1 us then 1 ms
        for (int t = 0; t < 2; t++) begin
            busWrite(8'h64, t ? 32'h0000_8021 : 32'h0000_0021);
            busWrite(8'h00, 32'h7f);
            busRead(8'h00, rd);
            chk("cleared", 0, rd); // Clear by write
            pipe.packet(1'b1, 4'h9, 3'h0, 3'h1, 3'h1, 7'h1);
            // In the millisecond run the early look falls past the latest microsecond expiry, so a wrong unit shows
            repeat (t ? 11 : 7) @(negedge clk_sys);
            chk("timerEarly", 0, irqOut); // Unit length
            repeat (t ? 40 : 20) @(negedge clk_sys);
            chk("timerExpire", 1, irqOut); // Expiry
            busRead(8'h00, rd);
            chk("timerStat", 32'h01, rd); // Port 1 status
        end
        test_done();
    end
endmodule : tb_acl_action_and_count_logic
